// ===== mme_params.svh
// constants for the move and multiply execution block
`ifndef MME_PARAMS_SVH
`define MME_PARAMS_SVH

// ==========================================================
// opcode fields
`define MME_OP_LOAD_BANK  8'h01
`define MME_OP_LOAD_ACC   8'h0e
`define MME_OP_MUL_LIT    8'h0d
`define MME_OP_MUL_FILE   7'h01
`define MME_OP_STORE      7'h37
`define MME_OP_COPY_SRC   4'hc
`define MME_OP_COPY_DST   4'hf

// ==========================================================
// addressing
`define MME_INDEX_MAX     8'h5f
`define MME_ACCESS_LOW    4'h0
`define MME_ACCESS_HIGH   4'hf
`define MME_ACC_ADDR      12'hfe8
`define MME_PC_LOW_ADDR   12'hff9
`define MME_STACK_L_ADDR  12'hffd
`define MME_STACK_H_ADDR  12'hffe
`define MME_STACK_U_ADDR  12'hfff

// ==========================================================
// reset values
`define MME_RESET_BYTE    8'h00
`define MME_RESET_ADDR    12'h000
`define MME_RESET_WORD    16'h0000

`endif

// ===== mme_pkg.sv
// types for the move and multiply execution block
package mme_pkg;

  // ==========================================================
  // instruction cycle phases
  typedef enum logic [3:0] {
    ph_q1 = 4'b0001,
    ph_q2 = 4'b0010,
    ph_q3 = 4'b0100,
    ph_q4 = 4'b1000
  } mme_phase_t;

  // ==========================================================
  // executed operations
  typedef enum logic [6:0] {
    op_none     = 7'b0000001,
    op_copy     = 7'b0000010,
    op_bank     = 7'b0000100,
    op_lit      = 7'b0001000,
    op_store    = 7'b0010000,
    op_mul_lit  = 7'b0100000,
    op_mul_file = 7'b1000000
  } mme_op_t;

endpackage

// ===== mme_mul8.sv
// unsigned 8x8 multiplier with registered product
`timescale 1ns/1ps
`default_nettype none
`include "mme_params.svh"

module mme_mul8 (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  a_i,
  input  wire logic [7:0]  b_i,
  output logic      [15:0] product_o
);

  // ==========================================================
  // product register
  // no carry, overflow or zero indication exists here at all
  wire [15:0] product_next = {8'h00, a_i} * {8'h00, b_i};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      product_o <= `MME_RESET_WORD;
    end else if (start_i) begin
      product_o <= product_next;
    end
  end

endmodule
`default_nettype wire

// ===== mme_exec.sv
// move and multiply instruction decode and execute core
`timescale 1ns/1ps
`default_nettype none
`include "mme_params.svh"

module mme_exec (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] instr_i,
  input  wire logic        instr_valid_i,
  input  wire logic        ext_set_en_i,
  input  wire logic [11:0] index_base_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic      [3:0]  phase_o,
  output logic      [11:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic      [7:0]  acc_o,
  output logic      [7:0]  bank_select_o,
  output logic      [7:0]  product_high_o,
  output logic      [7:0]  product_low_o,
  output logic             copy_pending_o
);
  import mme_pkg::*;

  // ==========================================================
  // state
  mme_phase_t  phase_reg;
  mme_op_t     op_reg;
  logic [7:0]  lit_reg;
  logic [11:0] addr_reg;
  logic [11:0] dest_reg;
  logic [7:0]  opnd_reg;
  logic        copy_pending_reg;
  logic [15:0] mul_product;

  // ==========================================================
  // decode of the word on the fetch path
  wire [7:0]  f_field    = instr_i[7:0];
  wire        a_bit      = instr_i[8];
  wire        f_low      = (f_field <= `MME_INDEX_MAX);
  wire        is_bank    = (instr_i[15:8] == `MME_OP_LOAD_BANK);
  wire        is_lit     = (instr_i[15:8] == `MME_OP_LOAD_ACC);
  wire        is_mul_lit = (instr_i[15:8] == `MME_OP_MUL_LIT);
  wire        is_mul_f   = (instr_i[15:9] == `MME_OP_MUL_FILE);
  wire        is_store   = (instr_i[15:9] == `MME_OP_STORE);
  wire        is_copy    = (instr_i[15:12] == `MME_OP_COPY_SRC);
  wire        is_dest    = (instr_i[15:12] == `MME_OP_COPY_DST);

  wire mme_op_t dec_op = is_copy    ? op_copy :
                         is_bank    ? op_bank :
                         is_lit     ? op_lit :
                         is_store   ? op_store :
                         is_mul_lit ? op_mul_lit :
                         is_mul_f   ? op_mul_file : op_none;

  // ==========================================================
  // file address generation
  wire        use_index   = ext_set_en_i & ~a_bit & f_low;
  wire [11:0] index_addr  = index_base_i + {4'h0, f_field};
  wire [11:0] access_addr = f_low ? {`MME_ACCESS_LOW, f_field}
                                  : {`MME_ACCESS_HIGH, f_field};
  wire [11:0] banked_addr = {bank_select_o[3:0], f_field};
  wire [11:0] file_addr   = use_index ? index_addr :
                            a_bit     ? banked_addr : access_addr;

  // copy operands span the whole 12-bit data space
  wire [11:0] copy_addr   = instr_i[11:0];
  wire [11:0] read_addr   = is_copy ? copy_addr : file_addr;
  wire        src_is_acc  = (read_addr == `MME_ACC_ADDR);
  wire        need_read   = (is_copy | is_mul_f) & ~src_is_acc;

  // ==========================================================
  // second word and destination checks
  wire        take_first  = (phase_reg == ph_q1) & ~copy_pending_reg & instr_valid_i;
  wire        take_second = (phase_reg == ph_q1) & copy_pending_reg & instr_valid_i & is_dest;
  wire        dest_acc    = (dest_reg == `MME_ACC_ADDR);
  wire        dest_block  = (dest_reg == `MME_PC_LOW_ADDR) |
                            (dest_reg == `MME_STACK_L_ADDR) |
                            (dest_reg == `MME_STACK_H_ADDR) |
                            (dest_reg == `MME_STACK_U_ADDR);
  wire        copy_second = (op_reg == op_copy) & ~copy_pending_reg;
  wire        capture_src = ((op_reg == op_copy) & copy_pending_reg) |
                            (op_reg == op_mul_file);
  wire        opnd_acc    = (addr_reg == `MME_ACC_ADDR);
  wire        is_mul_op   = (op_reg == op_mul_lit) | (op_reg == op_mul_file);
  wire [7:0]  mul_b       = (op_reg == op_mul_lit) ? lit_reg : opnd_reg;
  wire        write_mem   = (op_reg == op_store) |
                            (copy_second & ~dest_block & ~dest_acc);
  wire [11:0] write_addr  = (op_reg == op_store) ? addr_reg : dest_reg;
  wire [7:0]  write_data  = (op_reg == op_store) ? acc_o : opnd_reg;

  // ==========================================================
  // phase sequencer, four clocks per instruction cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= ph_q1;
    end else begin
      case (phase_reg)
        ph_q1:   phase_reg <= ph_q2;
        ph_q2:   phase_reg <= ph_q3;
        ph_q3:   phase_reg <= ph_q4;
        ph_q4:   phase_reg <= ph_q1;
        default: phase_reg <= ph_q1;
      endcase
    end
  end

  // ==========================================================
  // decode phase: latch operation and operands
  // a missing second copy word drops the copy rather than stalling the core
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_reg           <= op_none;
      lit_reg          <= `MME_RESET_BYTE;
      addr_reg         <= `MME_RESET_ADDR;
      dest_reg         <= `MME_RESET_ADDR;
      copy_pending_reg <= 1'b0;
    end else if (phase_reg == ph_q1) begin
      if (copy_pending_reg) begin
        op_reg           <= take_second ? op_copy : op_none;
        dest_reg         <= copy_addr;
        copy_pending_reg <= 1'b0;
      end else begin
        op_reg           <= take_first ? dec_op : op_none;
        lit_reg          <= instr_i[7:0];
        addr_reg         <= read_addr;
        copy_pending_reg <= take_first & is_copy;
      end
    end
  end

  // ==========================================================
  // read phase: operand capture, accumulator bypasses memory
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opnd_reg <= `MME_RESET_BYTE;
    end else if ((phase_reg == ph_q2) & capture_src) begin
      opnd_reg <= opnd_acc ? acc_o : mem_rdata_i;
    end
  end

  // ==========================================================
  // memory port: read strobe in the read phase, write in the write phase
  // second copy cycle issues no read, so no dummy access reaches memory
  // protected copy targets are gated before the strobe; memory knows nothing of them
  // address and data are registered, so memory sees them a full cycle before the edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_addr_o  <= `MME_RESET_ADDR;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= `MME_RESET_BYTE;
    end else begin
      mem_rd_o <= take_first & need_read;
      mem_wr_o <= (phase_reg == ph_q3) & write_mem;
      if (take_first) begin
        mem_addr_o <= read_addr;
      end else if (phase_reg == ph_q3) begin
        mem_addr_o  <= write_addr;
        mem_wdata_o <= write_data;
      end
    end
  end

  // ==========================================================
  // process phase: multiplier
  mme_mul8 u_mul (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .start_i   ((phase_reg == ph_q3) & is_mul_op),
    .a_i       (acc_o),
    .b_i       (mul_b),
    .product_o (mul_product)
  );

  // ==========================================================
  // write phase: core registers, no status flag is ever touched
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_o          <= `MME_RESET_BYTE;
      bank_select_o  <= `MME_RESET_BYTE;
      product_high_o <= `MME_RESET_BYTE;
      product_low_o  <= `MME_RESET_BYTE;
    end else if (phase_reg == ph_q4) begin
      if (op_reg == op_lit) begin
        acc_o <= lit_reg;
      end else if (copy_second & dest_acc) begin
        acc_o <= opnd_reg;
      end
      if (op_reg == op_bank) begin
        bank_select_o <= {4'h0, lit_reg[3:0]};
      end
      if (is_mul_op) begin
        product_high_o <= mul_product[15:8];
        product_low_o  <= mul_product[7:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_o        <= 4'h1;
      copy_pending_o <= 1'b0;
    end else begin
      phase_o        <= (phase_reg == ph_q4) ? 4'h1 : {phase_reg[2:0], 1'b0};
      copy_pending_o <= (phase_reg == ph_q1) ? (take_first & is_copy) : copy_pending_reg;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  phase_walk_a: assert property ((phase_reg == ph_q1) |=> (phase_reg == ph_q2) ##1
    (phase_reg == ph_q3) ##1 (phase_reg == ph_q4)) else $error("phase order broken");

  read_phase_a: assert property (mem_rd_o |-> (phase_reg == ph_q2) && !mem_wr_o)
    else $error("read outside read phase");

  load_acc_a: assert property (take_first && is_lit |->
    ##4 acc_o == $past(instr_i[7:0], 4)) else $error("literal not in accumulator");

  mul_lit_a: assert property (take_first && is_mul_lit |->
    ##4 {product_high_o, product_low_o} == $past(acc_o, 4) * $past(instr_i[7:0], 4))
    else $error("literal product wrong");

  mul_keep_acc_a: assert property (take_first && (is_mul_lit || is_mul_f) |->
    ##4 acc_o == $past(acc_o, 4)) else $error("multiply changed accumulator");

  store_write_a: assert property (take_first && is_store |->
    ##3 mem_wr_o && mem_wdata_o == $past(acc_o, 3)) else $error("store missing");

  bank_addr_a: assert property (take_first && is_mul_f && a_bit && !src_is_acc |->
    ##1 mem_rd_o && mem_addr_o == {$past(bank_select_o[3:0]), $past(f_field)})
    else $error("banked address wrong");

  index_addr_a: assert property (take_first && is_mul_f && use_index && !src_is_acc |->
    ##1 mem_addr_o == $past(index_base_i) + {4'h0, $past(f_field)})
    else $error("indexed address wrong");

  dest_block_a: assert property (mem_wr_o && (op_reg == op_copy) |->
    !(mem_addr_o inside {`MME_PC_LOW_ADDR, `MME_STACK_L_ADDR, `MME_STACK_H_ADDR,
    `MME_STACK_U_ADDR})) else $error("protected destination written");

  copy_write_a: assert property (take_second &&
    !(copy_addr inside {`MME_ACC_ADDR, `MME_PC_LOW_ADDR, `MME_STACK_L_ADDR,
    `MME_STACK_H_ADDR, `MME_STACK_U_ADDR}) |-> !mem_rd_o [*3] ##1
    (mem_wr_o && mem_addr_o == $past(copy_addr, 3) && mem_wdata_o == opnd_reg))
    else $error("copy write wrong");

  bank_load_a: assert property (take_first && is_bank |->
    ##4 bank_select_o == {4'h0, $past(instr_i[3:0], 4)}) else $error("bank load wrong");

  mul_file_a: assert property (take_first && is_mul_f && !src_is_acc |->
    ##4 {product_high_o, product_low_o} == $past(acc_o, 4) * $past(mem_rdata_i, 3))
    else $error("file product wrong");

  copy_src_read_a: assert property (take_first && is_copy && !src_is_acc |=>
    mem_rd_o && mem_addr_o == $past(copy_addr)) else $error("copy source read wrong");

  copy_acc_dest_a: assert property (take_second && (copy_addr == `MME_ACC_ADDR) |->
    ##4 acc_o == $past(opnd_reg, 3)) else $error("copy into accumulator wrong");

  lit_no_mem_a: assert property (take_first && (is_lit || is_bank || is_mul_lit) |=>
    (!mem_rd_o && !mem_wr_o) [*3]) else $error("literal op touched memory");

  store_addr_a: assert property (take_first && is_store && !a_bit && !use_index |->
    ##3 mem_wr_o && mem_addr_o == $past(access_addr, 3))
    else $error("quick-access store address wrong");

  copy_drop_a: assert property (copy_pending_reg && (phase_reg == ph_q1) &&
    !take_second |-> ##1 (!mem_wr_o) [*4]) else $error("dropped copy still wrote");

  phase_out_a: assert property (phase_o == phase_reg)
    else $error("phase indicator wrong");

  copy_seen_c: cover property (take_first && is_copy ##4 take_second);
  mul_file_c: cover property (take_first && is_mul_f && !src_is_acc ##1 mem_rd_o);
  store_c: cover property (take_first && is_store ##3 mem_wr_o);
  mul_lit_c: cover property (take_first && is_mul_lit);
  copy_drop_c: cover property (copy_pending_reg && (phase_reg == ph_q1) && !take_second);

endmodule
`default_nettype wire

// ===== mme_mem_model.sv
// data memory model on the far side of the execution core
`timescale 1ns/1ps
`default_nettype none

module mme_mem_model (
  input  wire logic        clock_i,
  input  wire logic [11:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:4095];
  logic [7:0] idle_reg = 8'h5a;
  int         n_writes = 0;
  int         n_reads = 0;

  // ==========================================================
  // read path
  // combinational read; outside a read the bus churns so a late sample shows up
  assign rdata_o = rd_i ? mem[addr_i] : idle_reg;

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'h00;
    end
  end

  // ==========================================================
  // write path, full 12-bit space
  always @(posedge clock_i) begin
    idle_reg <= ~idle_reg;
    if (rd_i === 1'b1) begin
      n_reads <= n_reads + 1;
    end
    if (wr_i === 1'b1) begin
      mem[addr_i] <= wdata_i;
      n_writes <= n_writes + 1;
    end
  end
endmodule
`default_nettype wire

// ===== test_move_and_multiply_exec.sv
// self-checking bench for the move and multiply execution core
`timescale 1ns/1ps
`default_nettype none
`include "mme_params.svh"

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

module test_move_and_multiply_exec;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic        instr_valid_i = 1'b0;
  logic        ext_set_en_i = 1'b0;
  logic [11:0] index_base_i = 12'h000;
  logic [7:0]  mem_rdata_i;
  logic [3:0]  phase_o;
  logic [11:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  acc_o;
  logic [7:0]  bank_select_o;
  logic [7:0]  product_high_o;
  logic [7:0]  product_low_o;
  logic        copy_pending_o;
  int          n_errors = 0;
  int          tests_run = 0;

  always #10 clock_i = ~clock_i;

  mme_exec dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .ext_set_en_i(ext_set_en_i),
    .index_base_i(index_base_i), .mem_rdata_i(mem_rdata_i), .phase_o(phase_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o), .acc_o(acc_o), .bank_select_o(bank_select_o),
    .product_high_o(product_high_o), .product_low_o(product_low_o),
    .copy_pending_o(copy_pending_o)
  );

  mme_mem_model mdl (
    .clock_i(clock_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i)
  );

  // ==========================================================
  // helpers
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one instruction cycle of four clocks, word taken at the first edge
  task automatic slot(input logic [15:0] w, input logic v);
    instr_i = w;
    instr_valid_i = v;
    @(posedge clock_i);
    #2;
    instr_valid_i = 1'b0;
    repeat (3) begin
      @(posedge clock_i);
      #2;
    end
  endtask

  task automatic copy(input logic [11:0] src, input logic [11:0] dst);
    int r;
    slot({4'hc, src}, 1'b1);
    `CHK(copy_pending_o, 1'b1)
    r = mdl.n_reads;
    slot({4'hf, dst}, 1'b1);
    `CHK(mdl.n_reads, r)
    `CHK(copy_pending_o, 1'b0)
  endtask

  // ==========================================================
  // scenarios
  task automatic t_literals();
    slot({8'h0e, 8'h5a}, 1'b1);
    `CHK(acc_o, 8'h5a)
    `CHK(phase_o, 4'h1)
    slot({8'h01, 8'hf7}, 1'b1);
    `CHK(bank_select_o, 8'h07)
    instr_i = {8'h0e, 8'hc4};
    instr_valid_i = 1'b1;
    @(posedge clock_i);
    #2;
    instr_valid_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #2;
    `CHK(acc_o, 8'h5a)
    @(posedge clock_i);
    #2;
    `CHK(acc_o, 8'hc4)
  endtask

  task automatic t_multiply();
    slot({8'h0d, 8'he2}, 1'b1);
    `CHK({product_high_o, product_low_o}, 16'had08)
    `CHK(acc_o, 8'hc4)
    slot({8'h0d, 8'h00}, 1'b1);
    `CHK({product_high_o, product_low_o}, 16'h0000)
    slot({8'h01, 8'h05}, 1'b1);
    mdl.mem[12'h520] = 8'hb5;
    slot({7'h01, 1'b1, 8'h20}, 1'b1);
    `CHK({product_high_o, product_low_o}, 16'h8a94)
    `CHK(mdl.mem[12'h520], 8'hb5)
  endtask

  task automatic store_chk(input logic a, input logic [7:0] f, input logic [11:0] ea);
    slot({7'h37, a, f}, 1'b1);
    `CHK(mdl.mem[ea], 8'h4f)
  endtask

  task automatic t_store();
    slot({8'h0e, 8'h4f}, 1'b1);
    store_chk(1'b1, 8'h30, 12'h530);
    store_chk(1'b0, 8'h10, 12'h010);
    store_chk(1'b0, 8'h80, 12'hf80);
    ext_set_en_i = 1'b1;
    index_base_i = 12'h300;
    store_chk(1'b0, 8'h5f, 12'h35f);
    store_chk(1'b0, 8'h60, 12'hf60);
    ext_set_en_i = 1'b0;
  endtask

  task automatic t_copy();
    int w;
    logic [11:0] prot [4];
    prot = '{`MME_PC_LOW_ADDR, `MME_STACK_L_ADDR, `MME_STACK_H_ADDR, `MME_STACK_U_ADDR};
    mdl.mem[12'h123] = 8'h33;
    mdl.mem[12'hfff] = 8'h77;
    copy(12'h123, 12'habc);
    `CHK(mdl.mem[12'habc], 8'h33)
    copy(12'hfff, 12'h000);
    `CHK(mdl.mem[12'h000], 8'h77)
    copy(`MME_ACC_ADDR, 12'h200);
    `CHK(mdl.mem[12'h200], 8'h4f)
    copy(12'h123, `MME_ACC_ADDR);
    `CHK(acc_o, 8'h33)
    foreach (prot[i]) begin
      w = mdl.n_writes;
      copy(12'h123, prot[i]);
      `CHK(mdl.n_writes, w)
    end
    w = mdl.n_writes;
    slot({4'hc, 12'h123}, 1'b1);
    slot({4'hf, 12'h345}, 1'b0);
    `CHK(mdl.n_writes, w)
    `CHK(copy_pending_o, 1'b0)
    `CHK(mdl.mem[12'h345], 8'h00)
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clock_i);
    #2;
    rst_n_i = 1'b1;
    t_literals();
    t_multiply();
    t_store();
    t_copy();
    end_of_test();
  end

  // generous: the sequence needs well under 200 clocks
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
